// File: hdl/pim_pkg.sv
// Package: register map, reset values and pin map of the parallel pin mux
package pim_pkg;
    localparam int unsigned NUM_SETS   = 3;
    localparam int unsigned SET_WIDTH  = 16;
    localparam int unsigned LOCK_BIT   = 15;
    localparam int unsigned ADDR_WIDTH = 12;

    // Byte offsets within the block, stride 0x10 per set
    localparam logic [11:0] OFS_DATA   = 12'h000;
    localparam logic [11:0] OFS_DIR    = 12'h004;
    localparam logic [11:0] OFS_SEL    = 12'h008;
    localparam logic [11:0] SET_STRIDE = 12'h010;

    // Reset values: data high, all inputs, all alternate function, unlocked
    localparam logic [14:0] DATA_RESET = 15'h7fff;
    localparam logic [14:0] DIR_RESET  = 15'h0000;
    localparam logic [14:0] SEL_RESET  = 15'h7fff;

    // Bits of each set that own a pin (set 0: 1..13, set 1: 0..14, set 2: 2..14)
    localparam logic [14:0] SET0_USED  = 15'h3ffe;
    localparam logic [14:0] SET1_USED  = 15'h7fff;
    localparam logic [14:0] SET2_USED  = 15'h7ffc;

    // Pin capability per set bit: can drive / can be an input
    localparam logic [14:0] SET0_OUT_OK = 15'h3ffe;
    localparam logic [14:0] SET1_OUT_OK = 15'h7fff;
    localparam logic [14:0] SET2_OUT_OK = 15'h7ffc;
    localparam logic [14:0] SET0_IN_OK  = 15'h3ffe;
    localparam logic [14:0] SET1_IN_OK  = 15'h7fff;
    localparam logic [14:0] SET2_IN_OK  = 15'h7ffc;

    // Alternate function drive direction per set bit: 1 = peripheral drives the pin
    localparam logic [14:0] SET0_ALT_OUT = 15'h3f06;
    localparam logic [14:0] SET1_ALT_OUT = 15'h0000;
    localparam logic [14:0] SET2_ALT_OUT = 15'h09dc;
endpackage : pim_pkg

// File: hdl/pim_regs_if.sv
// Interface: register values and write strobes between the bus slave and pin set logic
`timescale 1ns/10ps
`default_nettype none
interface pim_regs_if;
    logic [14:0] wdata;
    logic        wr_data;
    logic        wr_dir;
    logic        wr_sel;
    logic        lock_wr;
    logic [15:0] data_q;
    logic [15:0] dir_q;
    logic [15:0] sel_q;
    modport ctrl (output wdata, output wr_data, output wr_dir, output wr_sel, output lock_wr,
                  input data_q, input dir_q, input sel_q);
    modport set  (input wdata, input wr_data, input wr_dir, input wr_sel, input lock_wr,
                  output data_q, output dir_q, output sel_q);
endinterface : pim_regs_if
`default_nettype wire

// File: hdl/pim_set.sv
// One 15-bit register set: data, direction and function select with locks
`timescale 1ns/10ps
`default_nettype none
module pim_set #(
    parameter logic [14:0] USED   = 15'h7fff,
    parameter logic [14:0] OUT_OK = 15'h7fff,
    parameter logic [14:0] IN_OK  = 15'h7fff
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Register access
    pim_regs_if.set          regs,
    // Synchronised pin levels for read back
    input  wire logic [14:0] pin_level
);
    typedef struct packed {
        logic [14:0] data;
        logic [14:0] dir;
        logic [14:0] sel;
        logic        dir_lock;
        logic        sel_lock;
    } pim_set_state_type;

    pim_set_state_type st;
    pim_set_state_type next_st;

    always_comb begin
        next_st = st;
        if (regs.wr_data) begin
            next_st.data = regs.wdata & USED;
        end
        if (regs.wr_dir && !st.dir_lock) begin
            // Input-only pins never take an output direction, output-only stay output
            next_st.dir      = ((regs.wdata & OUT_OK) | ~IN_OK) & USED;
            next_st.dir_lock = regs.lock_wr;
        end
        if (regs.wr_sel && !st.sel_lock) begin
            next_st.sel      = regs.wdata & USED;
            next_st.sel_lock = regs.lock_wr;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.data     <= pim_pkg::DATA_RESET;
            st.dir      <= pim_pkg::DIR_RESET;
            st.sel      <= pim_pkg::SEL_RESET;
            st.dir_lock <= 1'b0;
            st.sel_lock <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Data reads return the pin level for inputs, the register for driven pins
    assign regs.data_q = {1'b0, ((st.dir & st.data) | (~st.dir & pin_level)) & USED};
    assign regs.dir_q  = {st.dir_lock, st.dir};
    assign regs.sel_q  = {st.sel_lock, st.sel};
endmodule : pim_set
`default_nettype wire

// File: hdl/pim_top.sv
// Parallel I/O pin mux: APB registers, three pin sets and the output multiplexer
// Function
// - Software sets each shared pin as input or output within its capability.
// - Each pin carries one alternate peripheral signal or software I/O.
// - Inputs toward peripherals get no extra synchroniser stages here.
// - Peripheral outputs pass the mux and then one register stage here before reaching the pads.
// - Pins are input-only, output-only or bidirectional; direction honours the class.
// - Each pin driven from its register bit; reads return the pin state, except pins with direction one, which read back the data register.
// - With alternate function, direction follows the peripheral signal direction.
// - Each pin maps to one set index and one bit for all registers.
// - Fixed map: set1 0-14 pins17-31, set2 12-14 pins14-16, 2-11 pins32-41, set0 1-13.
// - Direction one is output, zero input; resets to input.
// - Select one routes the peripheral, zero general purpose; resets to one.
// - Writing lock bit one blocks later direction or select writes.
// - Data bit one means high pin; data resets to one.
`timescale 1ns/10ps
`default_nettype none
module pim_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Pads, indexed by set*16+bit
    input  wire logic [47:0] pin_in,
    output var  logic [47:0] pin_out,
    output var  logic [47:0] pin_oe,
    // Peripheral side, same indexing
    input  wire logic [47:0] alt_out,
    input  wire logic [47:0] alt_oe,
    output var  logic [47:0] alt_in
);
    localparam logic [44:0] USED_ALL   = {pim_pkg::SET2_USED, pim_pkg::SET1_USED,
                                          pim_pkg::SET0_USED};
    localparam logic [44:0] ALTOUT_ALL = {pim_pkg::SET2_ALT_OUT, pim_pkg::SET1_ALT_OUT,
                                          pim_pkg::SET0_ALT_OUT};
    localparam logic [44:0] OUTOK_ALL  = {pim_pkg::SET2_OUT_OK, pim_pkg::SET1_OUT_OK,
                                          pim_pkg::SET0_OUT_OK};
    localparam logic [44:0] INOK_ALL   = {pim_pkg::SET2_IN_OK, pim_pkg::SET1_IN_OK,
                                          pim_pkg::SET0_IN_OK};

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [47:0] sync1;
        logic [47:0] sync2;
        logic [47:0] pout;
        logic [47:0] poe;
        logic [47:0] ain;
    } pim_top_state_type;

    pim_top_state_type st;
    pim_top_state_type next_st;

    pim_regs_if rif [3] ();
    logic [2:0] set_hit;
    logic [1:0] set_idx;
    logic [3:0] reg_ofs;
    logic       access;
    logic       hit;

    assign set_idx = paddr[5:4];
    assign reg_ofs = paddr[3:0];
    assign access  = psel && penable && !st.ready;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_set
            localparam int unsigned B = g * 15;
            assign set_hit[g]       = (set_idx == 2'(g)) && (paddr[11:6] == 6'h00)
                                      && (paddr[1:0] == 2'h0);
            assign rif[g].wdata     = pwdata[14:0];
            assign rif[g].lock_wr   = pwdata[pim_pkg::LOCK_BIT];
            assign rif[g].wr_data   = access && pwrite && set_hit[g]
                                      && reg_ofs == pim_pkg::OFS_DATA[3:0];
            assign rif[g].wr_dir    = access && pwrite && set_hit[g]
                                      && reg_ofs == pim_pkg::OFS_DIR[3:0];
            assign rif[g].wr_sel    = access && pwrite && set_hit[g]
                                      && reg_ofs == pim_pkg::OFS_SEL[3:0];
            pim_set #(
                .USED   (USED_ALL[B +: 15]),
                .OUT_OK (OUTOK_ALL[B +: 15]),
                .IN_OK  (INOK_ALL[B +: 15])
            ) u_set (
                .clk       (clk),
                .arst_n    (arst_n),
                .regs      (rif[g]),
                .pin_level (st.sync2[g*16 +: 15])
            );
        end
    endgenerate

    logic [15:0] rd_word [3];
    generate
        for (g = 0; g < 3; g++) begin : g_rd
            always_comb begin
                unique case (reg_ofs)
                    pim_pkg::OFS_DATA[3:0]: rd_word[g] = rif[g].data_q;
                    pim_pkg::OFS_DIR[3:0]:  rd_word[g] = rif[g].dir_q;
                    default:                rd_word[g] = rif[g].sel_q;
                endcase
            end
        end
    endgenerate

    assign hit = |set_hit && (reg_ofs == pim_pkg::OFS_DATA[3:0]
                 || reg_ofs == pim_pkg::OFS_DIR[3:0] || reg_ofs == pim_pkg::OFS_SEL[3:0]);

    // Elaboration checks: decode, pin packing and masks rely on this shape of the package
    generate
        if (pim_pkg::NUM_SETS != 3) begin : g_bad_sets
            $error("Pin mux serves exactly three register sets");
        end
        if (pim_pkg::SET_WIDTH != 16 || pim_pkg::LOCK_BIT != 15) begin : g_bad_width
            $error("Pin mux needs 16-bit sets with the lock in bit 15");
        end
        if (pim_pkg::ADDR_WIDTH != 12) begin : g_bad_addr
            $error("Pin mux decodes a 12-bit bus address");
        end
        if (pim_pkg::SET_STRIDE != 12'h010) begin : g_bad_stride
            $error("Set decode uses address bits 5:4, so the stride must be 0x10");
        end
        if (pim_pkg::OFS_DATA[11:4] != 8'h00 || pim_pkg::OFS_DIR[11:4] != 8'h00
            || pim_pkg::OFS_SEL[11:4] != 8'h00) begin : g_bad_ofs
            $error("Register offsets must lie inside one set stride");
        end
        if (pim_pkg::OFS_DATA[1:0] != 2'h0 || pim_pkg::OFS_DIR[1:0] != 2'h0
            || pim_pkg::OFS_SEL[1:0] != 2'h0) begin : g_bad_align
            $error("Register offsets must be word aligned");
        end
        if (pim_pkg::OFS_DATA == pim_pkg::OFS_DIR || pim_pkg::OFS_DATA == pim_pkg::OFS_SEL
            || pim_pkg::OFS_DIR == pim_pkg::OFS_SEL) begin : g_bad_dup
            $error("Register offsets must differ");
        end
        if ((OUTOK_ALL & ~USED_ALL) != 45'h0 || (INOK_ALL & ~USED_ALL) != 45'h0
            || (ALTOUT_ALL & ~USED_ALL) != 45'h0) begin : g_bad_mask
            $error("Capability or alternate drive set on a bit that owns no pad");
        end
    endgenerate

    // Per-pin multiplexer between the software bit and the alternate signal
    wire logic [47:0] mux_out;
    wire logic [47:0] mux_oe;
    wire logic [47:0] mux_ain;

    generate
        for (g = 0; g < 48; g++) begin : g_pin
            localparam int unsigned S   = g / 16;
            localparam int unsigned BIT = g % 16;
            if (BIT == 15) begin : g_lock_pos
                // The lock position of each set owns no pad
                assign mux_out[g] = 1'b0;
                assign mux_oe[g]  = 1'b0;
                assign mux_ain[g] = 1'b0;
            end else begin : g_pad
                localparam int unsigned K       = S * 15 + BIT;
                localparam bit          PAD     = USED_ALL[K];
                localparam bit          ALT_DRV = ALTOUT_ALL[K] && OUTOK_ALL[K];
                logic alt_sel;
                logic gp_drv;
                // Select resets to one on unmapped bits too, so mask it here
                assign alt_sel    = PAD && rif[S].sel_q[BIT];
                assign gp_drv     = PAD && rif[S].dir_q[BIT];
                // Direction follows the peripheral signal's own direction
                assign mux_out[g] = alt_sel ? alt_out[g]
                                  : (gp_drv && rif[S].data_q[BIT]);
                assign mux_oe[g]  = alt_sel ? (ALT_DRV && alt_oe[g]) : gp_drv;
                assign mux_ain[g] = alt_sel && pin_in[g];
            end
        end
    endgenerate

    always_comb begin
        next_st       = st;
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.ready = access;
        next_st.err   = access && !hit;
        next_st.rdata = '0;
        if (access && !pwrite && hit) begin
            next_st.rdata = {16'h0000, rd_word[set_idx]};
        end
        // Pads and the peripheral path take one register stage, nothing more
        next_st.pout  = mux_out;
        next_st.poe   = mux_oe;
        next_st.ain   = mux_ain;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // The output stage is the single register the top-level outputs require
    assign prdata  = st.rdata;
    assign pready  = st.ready;
    assign pslverr = st.err;
    assign pin_out = st.pout;
    assign pin_oe  = st.poe;
    assign alt_in  = st.ain;
endmodule : pim_top
`default_nettype wire

// File: tb/pim_chk.sv
// Checker: bus handshake and pad rules at the pin mux ports
`timescale 1ns/10ps
`default_nettype none
module pim_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pads and peripherals
    input wire logic [47:0] pin_in,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] alt_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Set 1 select as the bus leaves it; alternate inputs pass only while selected
    logic [14:0] sel1_seen;
    logic        sel1_lock;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel1_seen <= pim_pkg::SEL_RESET;
            sel1_lock <= 1'b0;
        end else if (psel && penable && pready && pwrite && !sel1_lock
                     && paddr == (pim_pkg::SET_STRIDE + pim_pkg::OFS_SEL)) begin
            sel1_seen <= pwdata[14:0];
            sel1_lock <= pwdata[pim_pkg::LOCK_BIT];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready;
    endsequence
    chk_ready_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("ready missing");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read not zero");
    chk_alt_in_pass: assert property ($past(arst_n) |->
        alt_in[30:16] == ($past(pin_in[30:16]) & sel1_seen))
        else $error("input path delay wrong");
    // Bits 0 of set 0, 0..1 of set 2 and every bit 15 own no pad
    chk_unused_quiet: assert property ((pin_oe & 48'h8003_8000_8001) == 48'h0)
        else $error("unused pad driven");
    chk_reset_inputs: assert property ($rose(arst_n) |-> (pin_oe[30:16] == 15'h0)[*2])
        else $error("pads driven after reset");
endmodule : pim_chk
bind pim_top pim_chk u_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_oe(pin_oe), .alt_in(alt_in));
`default_nettype wire

// File: tb/pim_pads.sv
// Pad model: board levels on released pads, own drive on driven ones
`timescale 1ns/10ps
`default_nettype none
module pim_pads (
    // From the block
    input  wire logic [47:0] pin_out,
    input  wire logic [47:0] pin_oe,
    // Board levels
    input  wire logic [47:0] ext_level,
    // To the block
    output var  logic [47:0] pin_in
);
    always_comb pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pim_pads
`default_nettype wire

// File: tb/pim_top_tb.sv
// Testbench: registers, pad drive, locks and alternate routing of the pin mux
`timescale 1ns/10ps
`default_nettype none
module pim_top_tb;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [47:0] pin_in, pin_out, pin_oe, alt_in;
    logic [47:0] alt_out = 48'h0;
    logic [47:0] alt_oe = 48'h0;
    logic [47:0] ext = 48'h0;
    int          errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #2.5 clk = ~clk;
    pim_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out),
        .alt_oe(alt_oe), .alt_in(alt_in));
    pim_pads u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        check(32'(n < 50), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    function automatic logic [11:0] addr(input int s, input int o);
        return 12'(16 * s + o);
    endfunction : addr
    function automatic logic [15:0] used(input int s);
        return {1'b0, s == 0 ? pim_pkg::SET0_USED : s == 1 ? pim_pkg::SET1_USED
                              : pim_pkg::SET2_USED};
    endfunction : used
    function automatic logic [15:0] alt_dir(input int s);
        return {1'b0, s == 0 ? pim_pkg::SET0_ALT_OUT : s == 1 ? pim_pkg::SET1_ALT_OUT
                              : pim_pkg::SET2_ALT_OUT};
    endfunction : alt_dir
    initial begin
        logic [15:0] d, dr, m;
        void'($urandom(32'h981242e6));
        do_reset();
        for (int s = 0; s < 3; s++) begin
            m = used(s);
            apb(1'b0, addr(s, 4), 32'h0);
            check(rd & {m | 16'h8000}, 32'h0);
            apb(1'b0, addr(s, 8), 32'h0);
            check(rd & {m | 16'h8000}, m);
            repeat (3) begin
                d = 16'($urandom);
                dr = 16'($urandom) & 16'h7fff;
                ext <= {16'($urandom), 16'($urandom), 16'($urandom)};
                apb(1'b1, addr(s, 8), 32'h0);
                apb(1'b1, addr(s, 4), dr);
                apb(1'b1, addr(s, 0), d);
                repeat (3) @(posedge clk);
                check(pin_oe[16*s +: 16] & m, dr & m);
                check(pin_out[16*s +: 16] & dr & m, d & dr & m);
                apb(1'b0, addr(s, 0), 32'h0);
                check(rd & m, ((d & dr) | (ext[16*s +: 16] & ~dr)) & m);
            end
        end
        $display("register and pad test done");
        apb(1'b1, addr(0, 4), 32'h8002);
        apb(1'b1, addr(0, 4), 32'h0004);
        apb(1'b0, addr(0, 4), 32'h0);
        check(rd, 32'h8002);
        apb(1'b1, addr(0, 8), 32'h8000);
        apb(1'b1, addr(0, 8), 32'h7fff);
        apb(1'b0, addr(0, 8), 32'h0);
        check(rd, 32'h8000);
        apb(1'b1, addr(0, 0), 32'h0);
        repeat (3) @(posedge clk);
        check({pin_oe[1], pin_out[1]}, 32'h2);
        apb(1'b0, 12'h0fc, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        $display("lock and error test done");
        do_reset();
        apb(1'b0, addr(0, 4), 32'h0);
        check(rd & 32'h8000, 32'h0);
        alt_oe <= {3{16'($urandom)}};
        alt_out <= {3{16'($urandom)}};
        repeat (4) @(posedge clk);
        for (int s = 0; s < 3; s++) begin
            m = used(s) & alt_dir(s) & alt_oe[16*s +: 16];
            check(pin_oe[16*s +: 16] & used(s), m);
            check(pin_out[16*s +: 16] & m, alt_out[16*s +: 16] & m);
        end
        $display("alternate test done");
        finish_test();
    end
endmodule : pim_top_tb
`default_nettype wire
